// ### common/sysio_cfg_pkg.sv
// system i/o configuration bank: offsets, fields, reset values, encodings
// assumes configuration cycles arrive already decoded to this function
// Contract
// - pin function one bit 15 moves channel-5 request onto channel-0 request pin
// - pin function one bit 14 turns pci grant 2 into chip select 1
// - bit 13 forces interrupt-3 pin to power event 2 unless trigger bit 12 is set, else group field decides
// - interrupt-2 pin follows group field unless trigger bit 11 is set; code 10 gives local device select
// - field 11:10 gives pci interrupt 1 or timer output 0
// - interrupt-0 field gives pci interrupt 0 or power event 1
// - field 7:6 follows group or forces acknowledge 7 on ack-3 pin
// - field 5:4 follows group, forces acknowledge 6 or chip select 2
// - field 3:2 follows group or forces acknowledge 5; code 11 unused
// - group field 1:0 picks explicit or encoded shared pin sets
// - cycle control bit 15 lets rom chip select assert on writes
// - field 13:12 divides local clock by 4, 3, 2 or 1 for isa clock
// - bit 11 sets one or zero clock turnaround for cpu pci writes
// - field 10:8 preempts pci master after 260 down to 5 clocks
// - bit 7 forwards dma/isa accesses while local memory unclaimed; retry at 16
// - bit 6 narrows transceiver direction to rom and nvram accesses
// - bits 5, 4, 3 enable parity to serr, address parity, abort serr
// - bit 1 picks slow subtractive sample point; resets to one
// - bit 0 makes vl cycles wait for pci initiator ready
// - pin function two assigns irq12, irq10, irq6, irq4 multiplexed inputs
// - request fields pick base, shared or high channel; pci_request1_n needs bit 1 clear
// - each rom segment bit enables a 32k segment; top boot segments inverted
// - trigger bits 12 and 11 force interrupt pins 3 and 2 to chip selects
package sysio_cfg_pkg;
  localparam logic [7:0] OFS_MISC_ONE = 8'h42;
  localparam logic [7:0] OFS_PIN_ONE = 8'h44;
  localparam logic [7:0] OFS_CYC_ONE = 8'h46;
  localparam logic [7:0] OFS_PIN_TWO = 8'h48;
  localparam logic [7:0] OFS_ROM_SEG = 8'h4a;

  localparam logic [15:0] RST_MISC_ONE = 16'h0000;
  localparam logic [15:0] RST_PIN_ONE = 16'h0000;
  localparam logic [15:0] RST_CYC_ONE = 16'h0006;
  localparam logic [15:0] RST_PIN_TWO = 16'h0000;
  localparam logic [15:0] RST_ROM_SEG = 16'h0000;
  // rom segment bits whose sense is inverted (0 = enabled)
  localparam logic [15:0] ROM_SEG_INVERT = 16'hc0c0;

  // pin function one fields
  localparam int PF1_DMA_REQ_CH5_MOVE = 15;
  localparam int PF1_GNT2_GPCS = 14;
  localparam int PF1_INT3_EPMI = 13;
  localparam int PF1_INT2_RSV = 12;
  localparam int PF1_INT1_LO = 10;
  localparam int PF1_INT0_LO = 8;
  localparam int PF1_ACK3_LO = 6;
  localparam int PF1_ACK1_LO = 4;
  localparam int PF1_ACK0_LO = 2;
  localparam int PF1_GROUP_LO = 0;
  // cycle control one fields
  localparam int CC_ROM_WR = 15;
  localparam int CC_ISA_DIV_LO = 12;
  localparam int CC_TURN_ZERO = 11;
  localparam int CC_PREEMPT_LO = 8;
  localparam int CC_DMA_FWD = 7;
  localparam int CC_XCVR_DIRECTION_NARROW = 6;
  localparam int CC_PERR_SERR = 5;
  localparam int CC_ADDR_PAR = 4;
  localparam int CC_TABORT_SERR = 3;
  localparam int CC_SLOW_SAMPLE = 1;
  localparam int CC_VL_WAIT = 0;
  // pin function two fields
  localparam int PF2_IRQ12_LO = 13;
  localparam int PF2_IRQ10_MUX = 12;
  localparam int PF2_IRQ6_MUX = 11;
  localparam int PF2_IRQ4_MUX = 10;
  localparam int PF2_DMA_REQ_CH7_LO = 8;
  localparam int PF2_DMA_REQ_CH3_LO = 6;
  localparam int PF2_DMA_REQ_CH1_LO = 4;
  localparam int PF2_DMA_REQ_CH0_LO = 2;
  localparam int PF2_PCI_REQUEST1_N_RSV = 1;

  localparam int RETRY_UNMASK_CLKS = 16;
  localparam logic [8:0] PREEMPT_CLKS_1 = 9'd260;
  localparam logic [8:0] PREEMPT_CLKS_2 = 9'd132;
  localparam logic [8:0] PREEMPT_CLKS_3 = 9'd68;
  localparam logic [8:0] PREEMPT_CLKS_4 = 9'd36;
  localparam logic [8:0] PREEMPT_CLKS_5 = 9'd20;
  localparam logic [8:0] PREEMPT_CLKS_6 = 9'd12;
  localparam logic [8:0] PREEMPT_CLKS_7 = 9'd5;

  typedef enum logic [1:0] {
    INT3_PCI = 2'b00, INT3_LRDY = 2'b01, INT3_EXT_PM_EVENT2_N = 2'b10, INT3_GP_CHIP_SELECT1_N = 2'b11
  } int3_fn_t;
  typedef enum logic [1:0] {
    INT2_PCI = 2'b00, INT2_LDEV = 2'b01, INT2_GP_CHIP_SELECT0_N = 2'b10
  } int2_fn_t;
  typedef enum logic [1:0] {
    ACK_EXPLICIT = 2'b00, ACK_ENCODED = 2'b01, ACK_HIGH = 2'b10, ACK_GPCS = 2'b11
  } ack_fn_t;
  typedef enum logic [1:0] {
    REQ_BASE = 2'b00, REQ_SHARED = 2'b01, REQ_HIGH = 2'b10, REQ_RSV = 2'b11
  } req_fn_t;
endpackage

// ### verilog/sysio_cfg_bank.sv
// system i/o configuration bank with pin routing, isa clock, preemption and rom decode
// assumes same-clock config strobes; trigger bits come from the neighbouring register
`timescale 1ns/100ps
module sysio_cfg_bank (
  input wire logic ref_clk, // local bus clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic cfg_sel, // config cycle strobe
  input wire logic cfg_we, // 1 write, 0 read
  input wire logic [7:0] cfg_addr, // config byte offset
  input wire logic [1:0] cfg_be, // byte enables
  input wire logic [15:0] cfg_wdata, // write data
  output logic [15:0] cfg_rdata, // read data
  output logic cfg_ack, // one-cycle answer
  input wire logic trig_int3_gp_chip_select1_n, // trigger reg bit 12
  input wire logic trig_int2_gp_chip_select0_n, // trigger reg bit 11
  output logic dma_req_ch5_on_dma_req_ch0, // channel-5 request on channel-0 pin
  output logic grant2_is_gp_chip_select1_n, // grant-2 pin is chip select 1
  output sysio_cfg_pkg::int3_fn_t int3_fn, // interrupt-3 pin function
  output sysio_cfg_pkg::int2_fn_t int2_fn, // interrupt-2 pin function
  output logic int1_is_timer0, // interrupt-1 pin drives timer0_output
  output logic int0_is_ext_pm_event1_n, // interrupt-0 pin is ext_pm_event1_n
  output sysio_cfg_pkg::ack_fn_t ack3_fn, // ack-3 pin function
  output sysio_cfg_pkg::ack_fn_t ack1_fn, // ack-1 pin function
  output sysio_cfg_pkg::ack_fn_t ack0_fn, // ack-0 pin function
  output logic [1:0] group_mode, // shared pin group
  output logic irq12_is_muxed, // irq12 pin is muxed_pci_int_2_3
  output logic irq10_is_muxed, // muxed_isa_int_10_12
  output logic irq6_is_muxed, // muxed_pci_int_0_1
  output logic irq4_is_muxed, // muxed_isa_int_4_6
  output sysio_cfg_pkg::req_fn_t dma_req_ch3_fn, // channel-3 request pin
  output sysio_cfg_pkg::req_fn_t dma_req_ch1_fn, // channel-1 request pin
  output sysio_cfg_pkg::req_fn_t dma_req_ch0_fn, // channel-0 request pin
  output logic dma_req_ch7_is_ext_pm_event1_n, // channel-7 request pin is event 1
  output logic pci_request1_n_enabled, // pci_request1_n active
  output logic isa_clk_tick, // one pulse per isa_bus_clock period
  output logic wr_turnaround, // 1 = one clock turnaround
  input wire logic pci_other_req, // unserviced request pending
  output logic pci_preempt, // preempt owning master
  input wire logic dma_isa_access, // dma/isa master cycle to pci/vl
  input wire logic local_mem_claim_n, // pin, asynchronous
  output logic dma_fwd, // forward the access
  output logic retry_unmask, // master retry unmasked
  input wire logic acc_rom, // rom access
  input wire logic acc_kbd, // keyboard controller access
  input wire logic acc_rtc, // clock chip access
  input wire logic acc_nvram, // nvram access
  output logic xcvr_direction, // transceiver direction
  output logic perr_serr_en, // data parity to system error
  output logic addr_parity_en, // address parity check
  output logic tabort_serr_en, // target abort system error
  output logic slow_sample, // subtractive decode slow point
  input wire logic vl_req, // vl cycle requested
  input wire logic pci_irdy_n, // pci initiator ready
  output logic vl_start, // vl cycle start
  input wire logic mem_cycle, // memory cycle valid
  input wire logic mem_write, // memory cycle is a write
  input wire logic [31:15] mem_addr, // 32k segment address
  output logic rom_chip_select_n // rom select
);
  import sysio_cfg_pkg::*;

  logic [15:0] misc_control_one_reg;
  logic [15:0] pin_function_one_reg;
  logic [15:0] cycle_control_one_reg;
  logic [15:0] pin_function_two_reg;
  logic [15:0] rom_segment_select_reg;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val, input logic [1:0] be);
    merge = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
  endfunction

  function automatic ack_fn_t ack_pick(input logic [1:0] fld, input logic [1:0] grp, input logic gp_ok);
    if (!fld[1]) begin
      ack_pick = grp[1] ? ACK_ENCODED : ACK_EXPLICIT;
    end else if (fld[0] && gp_ok) begin
      ack_pick = ACK_GPCS;
    end else begin
      ack_pick = ACK_HIGH;
    end
  endfunction

  function automatic req_fn_t req_pick(input logic [1:0] fld);
    req_pick = req_fn_t'(fld);
  endfunction

  wire wr_hit = cfg_sel && cfg_we;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      misc_control_one_reg <= RST_MISC_ONE;
      pin_function_one_reg <= RST_PIN_ONE;
      cycle_control_one_reg <= RST_CYC_ONE;
      pin_function_two_reg <= RST_PIN_TWO;
      rom_segment_select_reg <= RST_ROM_SEG;
    end else if (wr_hit) begin
      if (cfg_addr == OFS_MISC_ONE) misc_control_one_reg <= merge(misc_control_one_reg, cfg_wdata, cfg_be);
      if (cfg_addr == OFS_PIN_ONE) pin_function_one_reg <= merge(pin_function_one_reg, cfg_wdata, cfg_be);
      if (cfg_addr == OFS_CYC_ONE) cycle_control_one_reg <= merge(cycle_control_one_reg, cfg_wdata, cfg_be);
      if (cfg_addr == OFS_PIN_TWO) pin_function_two_reg <= merge(pin_function_two_reg, cfg_wdata, cfg_be);
      if (cfg_addr == OFS_ROM_SEG) rom_segment_select_reg <= merge(rom_segment_select_reg, cfg_wdata, cfg_be);
    end
  end

  // read answer, unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_rdata <= 16'h0000;
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_sel;
      cfg_rdata <= 16'h0000;
      if (cfg_sel && !cfg_we) begin
        unique case (cfg_addr)
          OFS_MISC_ONE: cfg_rdata <= misc_control_one_reg;
          OFS_PIN_ONE: cfg_rdata <= pin_function_one_reg;
          OFS_CYC_ONE: cfg_rdata <= cycle_control_one_reg;
          OFS_PIN_TWO: cfg_rdata <= pin_function_two_reg;
          OFS_ROM_SEG: cfg_rdata <= rom_segment_select_reg;
          default: cfg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  wire [15:0] pf1 = pin_function_one_reg;
  wire [15:0] pf2 = pin_function_two_reg;
  wire [15:0] cc = cycle_control_one_reg;
  wire [1:0] grp = pf1[PF1_GROUP_LO +: 2];

  // pin routing from register contents
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dma_req_ch5_on_dma_req_ch0 <= 1'b0;
      grant2_is_gp_chip_select1_n <= 1'b0;
      int3_fn <= INT3_PCI;
      int2_fn <= INT2_PCI;
      int1_is_timer0 <= 1'b0;
      int0_is_ext_pm_event1_n <= 1'b0;
      ack3_fn <= ACK_EXPLICIT;
      ack1_fn <= ACK_EXPLICIT;
      ack0_fn <= ACK_EXPLICIT;
      group_mode <= 2'b00;
    end else begin
      dma_req_ch5_on_dma_req_ch0 <= pf1[PF1_DMA_REQ_CH5_MOVE];
      grant2_is_gp_chip_select1_n <= pf1[PF1_GNT2_GPCS];
      if (trig_int3_gp_chip_select1_n) begin
        int3_fn <= INT3_GP_CHIP_SELECT1_N;
      end else if (pf1[PF1_INT3_EPMI]) begin
        int3_fn <= INT3_EXT_PM_EVENT2_N;
      end else begin
        int3_fn <= (grp == 2'b10) ? INT3_LRDY : INT3_PCI;
      end
      if (trig_int2_gp_chip_select0_n) begin
        int2_fn <= INT2_GP_CHIP_SELECT0_N;
      end else begin
        int2_fn <= (grp == 2'b10) ? INT2_LDEV : INT2_PCI;
      end
      int1_is_timer0 <= (pf1[PF1_INT1_LO +: 2] == 2'b01);
      // power event 1 on interrupt 0
      int0_is_ext_pm_event1_n <= (pf1[PF1_INT0_LO +: 2] == 2'b01);
      ack3_fn <= ack_pick(pf1[PF1_ACK3_LO +: 2], grp, 1'b0);
      ack1_fn <= ack_pick(pf1[PF1_ACK1_LO +: 2], grp, 1'b1);
      // acknowledge-0 pin, code 11 treated as 10
      ack0_fn <= ack_pick(pf1[PF1_ACK0_LO +: 2], grp, 1'b0);
      group_mode <= grp;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq12_is_muxed <= 1'b0;
      irq10_is_muxed <= 1'b0;
      irq6_is_muxed <= 1'b0;
      irq4_is_muxed <= 1'b0;
      dma_req_ch3_fn <= REQ_BASE;
      dma_req_ch1_fn <= REQ_BASE;
      dma_req_ch0_fn <= REQ_BASE;
      dma_req_ch7_is_ext_pm_event1_n <= 1'b0;
      pci_request1_n_enabled <= 1'b1;
    end else begin
      irq12_is_muxed <= (pf2[PF2_IRQ12_LO +: 2] == 2'b10);
      irq10_is_muxed <= pf2[PF2_IRQ10_MUX];
      irq6_is_muxed <= pf2[PF2_IRQ6_MUX];
      irq4_is_muxed <= pf2[PF2_IRQ4_MUX];
      dma_req_ch3_fn <= req_pick(pf2[PF2_DMA_REQ_CH3_LO +: 2]);
      dma_req_ch1_fn <= req_pick(pf2[PF2_DMA_REQ_CH1_LO +: 2]);
      dma_req_ch0_fn <= req_pick(pf2[PF2_DMA_REQ_CH0_LO +: 2]);
      dma_req_ch7_is_ext_pm_event1_n <= (pf2[PF2_DMA_REQ_CH7_LO +: 2] == 2'b01);
      pci_request1_n_enabled <= !pf2[PF2_PCI_REQUEST1_N_RSV];
    end
  end

  logic [1:0] isa_cnt_reg;
  wire [1:0] isa_last = 2'd3 - cc[CC_ISA_DIV_LO +: 2];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      isa_cnt_reg <= 2'd0;
      isa_clk_tick <= 1'b0;
    end else begin
      isa_clk_tick <= (isa_cnt_reg >= isa_last);
      isa_cnt_reg <= (isa_cnt_reg >= isa_last) ? 2'd0 : isa_cnt_reg + 2'd1;
    end
  end

  function automatic logic [8:0] preempt_limit(input logic [2:0] code);
    unique case (code)
      3'd1: preempt_limit = PREEMPT_CLKS_1;
      3'd2: preempt_limit = PREEMPT_CLKS_2;
      3'd3: preempt_limit = PREEMPT_CLKS_3;
      3'd4: preempt_limit = PREEMPT_CLKS_4;
      3'd5: preempt_limit = PREEMPT_CLKS_5;
      3'd6: preempt_limit = PREEMPT_CLKS_6;
      3'd7: preempt_limit = PREEMPT_CLKS_7;
      default: preempt_limit = 9'd0;
    endcase
  endfunction

  logic [8:0] wait_cnt_reg;
  wire [2:0] pre_code = cc[CC_PREEMPT_LO +: 3];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wait_cnt_reg <= 9'd0;
      pci_preempt <= 1'b0;
    end else if (!pci_other_req || pre_code == 3'd0) begin
      wait_cnt_reg <= 9'd0;
      pci_preempt <= 1'b0;
    end else begin
      if (wait_cnt_reg != 9'h1ff) wait_cnt_reg <= wait_cnt_reg + 9'd1;
      pci_preempt <= ({1'b0, wait_cnt_reg} + 10'd1 >= {1'b0, preempt_limit(pre_code)});
    end
  end

  // local memory claim pin, three stages, change when last two agree
  logic local_mem_claim_n_s1_reg, local_mem_claim_n_s2_reg, local_mem_claim_n_s3_reg, local_mem_claim_n_n_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      local_mem_claim_n_s1_reg <= 1'b1;
      local_mem_claim_n_s2_reg <= 1'b1;
      local_mem_claim_n_s3_reg <= 1'b1;
      local_mem_claim_n_n_reg <= 1'b1;
    end else begin
      local_mem_claim_n_s1_reg <= local_mem_claim_n;
      local_mem_claim_n_s2_reg <= local_mem_claim_n_s1_reg;
      local_mem_claim_n_s3_reg <= local_mem_claim_n_s2_reg;
      if (local_mem_claim_n_s2_reg == local_mem_claim_n_s3_reg) local_mem_claim_n_n_reg <= local_mem_claim_n_s3_reg;
    end
  end

  logic [4:0] retry_cnt_reg;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dma_fwd <= 1'b0;
      retry_cnt_reg <= 5'd0;
      retry_unmask <= 1'b0;
    end else begin
      dma_fwd <= dma_isa_access && cc[CC_DMA_FWD] && local_mem_claim_n_n_reg;
      if (!dma_isa_access) begin
        retry_cnt_reg <= 5'd0;
        retry_unmask <= 1'b0;
      end else begin
        if (retry_cnt_reg != 5'(RETRY_UNMASK_CLKS)) retry_cnt_reg <= retry_cnt_reg + 5'd1;
        retry_unmask <= (retry_cnt_reg + 5'd1 >= 5'(RETRY_UNMASK_CLKS));
      end
    end
  end

  function automatic logic seg_enabled(input logic [31:15] a, input logic [15:0] sel);
    logic [15:0] en;
    en = sel ^ ROM_SEG_INVERT;
    seg_enabled = 1'b0;
    // top 256k of the 4g space: bits 15:8
    if (a[31:18] == 14'h3fff) begin
      seg_enabled = en[{1'b1, a[17:15]}];
    // c0000 to fffff below 1m: bits 7:0
    end else if (a[31:18] == 14'h0003) begin
      seg_enabled = en[{1'b0, a[17:15]}];
    end
  endfunction

  // misc outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_turnaround <= 1'b1;
      xcvr_direction <= 1'b0;
      perr_serr_en <= 1'b0;
      addr_parity_en <= 1'b0;
      tabort_serr_en <= 1'b0;
      slow_sample <= 1'b1;
      vl_start <= 1'b0;
      rom_chip_select_n <= 1'b1;
    end else begin
      wr_turnaround <= !cc[CC_TURN_ZERO];
      xcvr_direction <= acc_rom || acc_nvram || (!cc[CC_XCVR_DIRECTION_NARROW] && (acc_kbd || acc_rtc));
      perr_serr_en <= cc[CC_PERR_SERR];
      addr_parity_en <= cc[CC_ADDR_PAR];
      tabort_serr_en <= cc[CC_TABORT_SERR];
      slow_sample <= cc[CC_SLOW_SAMPLE];
      vl_start <= vl_req && (!cc[CC_VL_WAIT] || !pci_irdy_n);
      rom_chip_select_n <= !(mem_cycle && seg_enabled(mem_addr, rom_segment_select_reg)
                             && (!mem_write || cc[CC_ROM_WR]));
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_rom_write_protect: assert property ((mem_cycle && mem_write && !cc[CC_ROM_WR]) |=> rom_chip_select_n)
    else $error("rom select on protected write");
  a_int3_trig_win: assert property (trig_int3_gp_chip_select1_n |=> int3_fn == INT3_GP_CHIP_SELECT1_N)
    else $error("trigger override lost on interrupt 3");
  a_int3_epmi_sel: assert property ((!trig_int3_gp_chip_select1_n && pf1[PF1_INT3_EPMI]) |=> int3_fn == INT3_EXT_PM_EVENT2_N)
    else $error("interrupt 3 not power event");
  a_ack1_gpcs: assert property ((pf1[5:4] == 2'b11) |=> ack1_fn == ACK_GPCS)
    else $error("ack1 chip select missing");
  a_ack3_group: assert property ((pf1[7:6] == 2'b00 && grp[1]) |=> ack3_fn == ACK_ENCODED)
    else $error("ack3 group decode wrong");
  a_preempt_five: assert property ((pre_code == 3'd7 && pci_other_req && !pci_preempt && wait_cnt_reg == 9'd0)
    ##1 (pre_code == 3'd7 && pci_other_req) [*4] |=> pci_preempt)
    else $error("preempt not after 5 clocks");
  a_preempt_off: assert property ((pre_code == 3'd0) |=> !pci_preempt)
    else $error("preempt while disabled");
  a_retry_sixteen: assert property ($rose(retry_unmask) |-> retry_cnt_reg == 5'd16)
    else $error("retry unmask count wrong");
  a_vl_wait_irdy: assert property ((cc[CC_VL_WAIT] && pci_irdy_n) |=> !vl_start)
    else $error("vl start before initiator ready");
  a_xcvr_direction_narrow: assert property ((cc[CC_XCVR_DIRECTION_NARROW] && acc_kbd && !acc_rom && !acc_nvram) |=> !xcvr_direction)
    else $error("transceiver direction on keyboard access");
  a_isa_tick_div: assert property ((cc[13:12] == 2'b10) [*3] |-> (isa_clk_tick != $past(isa_clk_tick)))
    else $error("isa tick not every second clock");
  a_read_back: assert property ((cfg_sel && !cfg_we && cfg_addr == OFS_CYC_ONE) |=> cfg_rdata == $past(cc))
    else $error("cycle control read back wrong");
  a_int2_trig_win: assert property (trig_int2_gp_chip_select0_n |=> int2_fn == INT2_GP_CHIP_SELECT0_N)
    else $error("trigger override lost on interrupt 2");
  a_ack0_forced: assert property ((pf1[3:2] == 2'b10) |=> ack0_fn == ACK_HIGH)
    else $error("ack0 high channel missing");
  a_grant2_alt: assert property (pf1[PF1_GNT2_GPCS] |=> grant2_is_gp_chip_select1_n)
    else $error("grant 2 alternate missing");
  a_turn_zero: assert property (cc[CC_TURN_ZERO] |=> !wr_turnaround)
    else $error("turnaround not removed");
  a_preempt_hold: assert property ((pci_other_req && pre_code != 3'd0 && wait_cnt_reg == 9'h1ff) |=> pci_preempt)
    else $error("preempt dropped after long wait");
  a_fwd_claimed: assert property (!local_mem_claim_n_n_reg |=> !dma_fwd)
    else $error("forward while local memory claimed");
  a_cfg_ack_pulse: assert property (cfg_sel |=> cfg_ack)
    else $error("config strobe not acknowledged");
  a_wr_rdata_zero: assert property ((cfg_sel && cfg_we) |=> cfg_rdata == 16'h0000)
    else $error("read data after write not zero");
  a_top_boot_seg: assert property ((mem_cycle && (!mem_write || cc[CC_ROM_WR]) && mem_addr[31:18] == 14'h3fff
    && !rom_segment_select_reg[15] && mem_addr[17:15] == 3'd7) |=> !rom_chip_select_n)
    else $error("top boot segment not selected");
endmodule // sysio_cfg_bank

// ### tb/sysio_cfg_bank_tb.sv
// testbench for the system i/o configuration bank: register access, pin routing, timing outputs
// assumes a one-cycle ack per config strobe and outputs registered one cycle behind their cause
`timescale 1ns/100ps
module sysio_cfg_bank_tb;
  import sysio_cfg_pkg::*;
  logic ref_clk = 1'b0, sys_rst = 1'b1, cfg_sel = 1'b0, cfg_we = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [1:0] cfg_be = 2'h0;
  logic [15:0] cfg_wdata = 16'h0000, cfg_rdata, rd;
  logic trig_int3_gp_chip_select1_n = 1'b0, trig_int2_gp_chip_select0_n = 1'b0, pci_other_req = 1'b0, dma_isa_access = 1'b0;
  logic local_mem_claim_n = 1'b1, acc_rom = 1'b0, acc_kbd = 1'b0, acc_rtc = 1'b0, acc_nvram = 1'b0;
  logic vl_req = 1'b0, pci_irdy_n = 1'b1, mem_cycle = 1'b0, mem_write = 1'b0;
  logic [31:15] mem_addr = 17'h00000;
  logic cfg_ack, dma_req_ch5_on_dma_req_ch0, grant2_is_gp_chip_select1_n, int1_is_timer0, int0_is_ext_pm_event1_n, irq12_is_muxed;
  logic irq10_is_muxed, irq6_is_muxed, irq4_is_muxed, dma_req_ch7_is_ext_pm_event1_n, pci_request1_n_enabled, isa_clk_tick;
  logic wr_turnaround, pci_preempt, dma_fwd, retry_unmask, xcvr_direction, perr_serr_en;
  logic addr_parity_en, tabort_serr_en, slow_sample, vl_start, rom_chip_select_n;
  logic [1:0] group_mode;
  int3_fn_t int3_fn;
  int2_fn_t int2_fn;
  ack_fn_t ack3_fn, ack1_fn, ack0_fn;
  req_fn_t dma_req_ch3_fn, dma_req_ch1_fn, dma_req_ch0_fn;
  int failures = 0, checks_done = 0;
  logic [7:0] offs [5] = '{OFS_MISC_ONE, OFS_PIN_ONE, OFS_CYC_ONE, OFS_PIN_TWO, OFS_ROM_SEG};
  logic [15:0] rsts [5] = '{RST_MISC_ONE, RST_PIN_ONE, RST_CYC_ONE, RST_PIN_TWO, RST_ROM_SEG};
  wire [4:0] probe = {isa_clk_tick, vl_start, dma_fwd, retry_unmask, pci_preempt};

  sysio_cfg_bank DUT (.ref_clk, .sys_rst, .cfg_sel, .cfg_we, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .cfg_ack, .trig_int3_gp_chip_select1_n, .trig_int2_gp_chip_select0_n, .dma_req_ch5_on_dma_req_ch0, .grant2_is_gp_chip_select1_n, .int3_fn, .int2_fn,
    .int1_is_timer0, .int0_is_ext_pm_event1_n, .ack3_fn, .ack1_fn, .ack0_fn, .group_mode, .irq12_is_muxed,
    .irq10_is_muxed, .irq6_is_muxed, .irq4_is_muxed, .dma_req_ch3_fn, .dma_req_ch1_fn, .dma_req_ch0_fn, .dma_req_ch7_is_ext_pm_event1_n,
    .pci_request1_n_enabled, .isa_clk_tick, .wr_turnaround, .pci_other_req, .pci_preempt, .dma_isa_access,
    .local_mem_claim_n, .dma_fwd, .retry_unmask, .acc_rom, .acc_kbd, .acc_rtc, .acc_nvram, .xcvr_direction,
    .perr_serr_en, .addr_parity_en, .tabort_serr_en, .slow_sample, .vl_req, .pci_irdy_n, .vl_start,
    .mem_cycle, .mem_write, .mem_addr, .rom_chip_select_n);

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one access, ack looked at in its single cycle, then one more cycle for derived outputs
  task automatic cfg_op(input logic we, input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge ref_clk);
    cfg_sel = 1'b1;
    cfg_we = we;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_sel = 1'b0;
    rd = cfg_rdata;
    check({15'h0000, cfg_ack}, 16'h0001);
    @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cfg_op(1'b1, a, 2'h3, d);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [15:0] exp);
    cfg_op(1'b0, a, 2'h3, 16'h0000);
    check(rd, exp);
  endtask

  // bounded wait for a probed output to reach a level; n counts falling edges passed
  task automatic wait_bit(input int idx, input logic val, input int lo, input int hi);
    int n = 0;
    while (probe[idx] !== val && n <= hi) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, n >= lo && n <= hi}, 16'h0001);
    if (n > hi) report_and_stop();
  endtask

  task automatic pin_case(input logic [15:0] pf, input logic [1:0] trig, input logic [15:0] exp);
    {trig_int3_gp_chip_select1_n, trig_int2_gp_chip_select0_n} = trig;
    wr(OFS_PIN_ONE, pf);
    check({dma_req_ch5_on_dma_req_ch0, grant2_is_gp_chip_select1_n, int1_is_timer0, int0_is_ext_pm_event1_n, int3_fn, int2_fn, ack3_fn, ack1_fn,
      ack0_fn, group_mode}, exp);
  endtask

  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) rd_check(offs[i], rsts[i]);
    check({12'h000, wr_turnaround, slow_sample, pci_request1_n_enabled, rom_chip_select_n}, 16'h000f);
    for (int i = 0; i < 5; i++) wr(offs[i], 16'ha5a5 ^ 16'(i));
    for (int i = 0; i < 5; i++) rd_check(offs[i], 16'ha5a5 ^ 16'(i));
    wr(8'h4c, 16'hffff);
    rd_check(8'h4c, 16'h0000);
    cfg_op(1'b1, OFS_MISC_ONE, 2'h1, 16'h1234);
    rd_check(OFS_MISC_ONE, 16'ha534);
    pin_case(16'h0002, 2'h0, 16'h0556);
    pin_case(16'h0001, 2'h0, 16'h0001);
    pin_case(16'h2003, 2'h0, 16'h0857);
    pin_case(16'h00b8, 2'h0, 16'h00b8);
    pin_case(16'h0062, 2'h0, 16'h0566);
    pin_case(16'h2002, 2'h3, 16'h0e56);
    pin_case(16'hc500, 2'h0, 16'hf000);
    pin_case(16'h1a00, 2'h0, 16'h0000);
    wr(OFS_PIN_TWO, 16'h5d98);
    check({4'h0, irq12_is_muxed, irq10_is_muxed, irq6_is_muxed, irq4_is_muxed, dma_req_ch7_is_ext_pm_event1_n, pci_request1_n_enabled,
      dma_req_ch3_fn, dma_req_ch1_fn, dma_req_ch0_fn}, 16'h0fe6);
    wr(OFS_PIN_TWO, 16'h2002);
    check({4'h0, irq12_is_muxed, pci_request1_n_enabled, dma_req_ch0_fn}, 16'h0000);
    wr(OFS_CYC_ONE, 16'h0838);
    check({11'h000, wr_turnaround, perr_serr_en, addr_parity_en, tabort_serr_en, slow_sample}, 16'h000e);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CYC_ONE, (16'(c) << 12) | 16'h0006);
      wait_bit(4, 1'b1, 0, 8);
      @(negedge ref_clk);
      wait_bit(4, 1'b1, 3 - c, 3 - c);
    end
    wr(OFS_CYC_ONE, 16'h0706);
    pci_other_req = 1'b1;
    wait_bit(0, 1'b1, 5, 6);
    pci_other_req = 1'b0;
    wait_bit(0, 1'b0, 1, 2);
    wr(OFS_CYC_ONE, 16'h0106);
    pci_other_req = 1'b1;
    wait_bit(0, 1'b1, 260, 261);
    pci_other_req = 1'b0;
    wait_bit(0, 1'b0, 1, 2);
    wr(OFS_CYC_ONE, 16'h0006);
    pci_other_req = 1'b1;
    dma_isa_access = 1'b1;
    wait_bit(1, 1'b1, 16, 17);
    repeat (270) @(negedge ref_clk);
    check({14'h0000, pci_preempt, dma_fwd}, 16'h0000);
    pci_other_req = 1'b0;
    wr(OFS_CYC_ONE, 16'h0086);
    wait_bit(2, 1'b1, 0, 8);
    local_mem_claim_n = 1'b0;
    wait_bit(2, 1'b0, 1, 8);
    dma_isa_access = 1'b0;
    wr(OFS_CYC_ONE, 16'h0006);
    vl_req = 1'b1;
    wait_bit(3, 1'b1, 1, 3);
    vl_req = 1'b0;
    wr(OFS_CYC_ONE, 16'h0007);
    vl_req = 1'b1;
    settle();
    check({15'h0000, vl_start}, 16'h0000);
    pci_irdy_n = 1'b0;
    wait_bit(3, 1'b1, 1, 3);
    vl_req = 1'b0;
    acc_kbd = 1'b1;
    wr(OFS_CYC_ONE, 16'h0006);
    check({15'h0000, xcvr_direction}, 16'h0001);
    wr(OFS_CYC_ONE, 16'h0046);
    check({15'h0000, xcvr_direction}, 16'h0000);
    acc_kbd = 1'b0;
    acc_nvram = 1'b1;
    settle();
    check({15'h0000, xcvr_direction}, 16'h0001);
    wr(OFS_ROM_SEG, 16'h0010);
    mem_addr = 17'h0001c;
    mem_cycle = 1'b1;
    settle();
    check({15'h0000, rom_chip_select_n}, 16'h0000);
    mem_write = 1'b1;
    settle();
    check({15'h0000, rom_chip_select_n}, 16'h0001);
    wr(OFS_CYC_ONE, 16'h8006);
    check({15'h0000, rom_chip_select_n}, 16'h0000);
    mem_addr = 17'h0001e;
    settle();
    check({15'h0000, rom_chip_select_n}, 16'h0000);
    wr(OFS_ROM_SEG, 16'h0054);
    check({15'h0000, rom_chip_select_n}, 16'h0001);
    mem_addr = 17'h0001a;
    settle();
    check({15'h0000, rom_chip_select_n}, 16'h0000);
    mem_addr = 17'h1ffff;
    settle();
    check({15'h0000, rom_chip_select_n}, 16'h0000);
    wr(OFS_ROM_SEG, 16'h8054);
    check({15'h0000, rom_chip_select_n}, 16'h0001);
    report_and_stop();
  end
endmodule // sysio_cfg_bank_tb
